// ==== qsw_host_model.sv ====
// Serial host model: sends frames most significant bit first and collects the reply
`timescale 1ns/1ps
module qsw_host_model
(
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe_n
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    o_sdi = 1'b0;
    // A clean rising select clears the link-side frame state before any frame
    #1;
    o_cs_n = 1'b1;
  end
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rx);
    rx = 16'h0;
    o_cs_n = 1'b0;
    #407;
    for (int i = 0; i < nbits; i++)
    begin
      o_sclk = 1'b1;
      o_sdi = word[15-i];
      #24;
      rx = {rx[14:0], i_sdo_oe_n ? ~rx[0] : i_sdo};
      o_sclk = 1'b0;
      #24;
    end
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #500;
  endtask : xfer
endmodule : qsw_host_model

// ==== qsw_pkg.sv ====
// Constants and types of the quad high-side switch supervisor
// Behaviour
// R01: Serial words are 16 bits each way, most significant bit first.
// R02: Host keeps the reset pin high through every transfer to be accepted.
// R03: Exactly four modes: Sleep, Normal, Fault, Fail-safe, chosen by pins, faults, watchdog.
// R04: After battery power-up the device sits in Sleep with all outputs off.
// R05: Wake and reset pins both low put the device in Sleep.
// R06: In Sleep every serially configurable setting acts as zero.
// R07: Normal needs reset pin high, supplies in range, no fault; fault pin high.
// R08: Unless fail-safe select is grounded, a rising wake or reset pin starts the watchdog.
// R09: Watchdog timeout is an oscillator-period multiple chosen by the period select.
// R10: Host toggles bit D15 within the timeout; each toggle restarts the watchdog.
// R11: Watchdog expiry enters Fail-safe, held until reinitialised.
// R12: Fail-safe outputs follow the select level: all off, channel 0, or channels 0 and 2.
// R13: Entering Fail-safe restores overcurrent levels, timing and overtemp latch modes to defaults.
// R14: Watchdog-expired flag at status bit D2 reads one during Fail-safe.
// R15: Fail-safe ends when wake and reset fall together or select is grounded.
// R16: Grounded fail-safe select disables watchdog and Fail-safe.
// R17: Logic supply loss resets registers; direct inputs drive outputs; watchdog runs on defaults.
// R18: Fault pin goes low on overtemp, over/undervoltage, open load or overcurrent.
// R19: Fault pin self-releases except overcurrent, latched overtemp and some undervoltage.
// R20: A latched fault releases only on a new switch-on command, serial or direct.
// R21: Fault register is shifted out in the first valid transfer and cleared by it.
// R22: Status loads at chip select fall; received word commits at chip select rise.
// R23: Input sampled on serial clock fall, output changes on rise; clock low at select edges.
// R24: With chip select high the serial clock and input are ignored, output floats.
// R25: Fail-safe select arrives as a two-bit code: disabled, all off, ch0, ch0 and ch2.
package qsw_pkg;
  localparam int CH_N = 4;
  localparam int WORD_W = 16;
  localparam int WD_BIT = 15;
  localparam int ADDR_LO = 10;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 10;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_OVERCURRENT = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_OVERTEMP = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_WATCHDOG = 5'h04;
  localparam int OUT_ON_LO = 0;
  localparam int OUT_EN_LO = 4;
  localparam int OCL_LO = 0;
  localparam int OCH_BIT = 3;
  localparam int OCT_LO = 4;
  localparam int OTL_LO = 0;
  localparam int WDR_LO = 0;
  localparam logic [3:0] DEF_SPI_ON = 4'h0;
  localparam logic [3:0] DEF_IN_EN = 4'hf;
  localparam logic [2:0] DEF_OCL = 3'h3;
  localparam logic DEF_OCH = 1'h0;
  localparam logic [2:0] DEF_OCT = 3'h2;
  localparam logic [3:0] DEF_OTL = 4'h0;
  localparam logic [1:0] DEF_WDR = 2'h0;
  localparam logic [1:0] FS_DISABLED = 2'h0;
  localparam logic [1:0] FS_ALL_OFF = 2'h1;
  localparam logic [1:0] FS_CH0 = 2'h2;
  localparam logic [1:0] FS_CH0_CH2 = 2'h3;
  localparam logic [3:0] PAT_ALL_OFF = 4'h0;
  localparam logic [3:0] PAT_CH0 = 4'h1;
  localparam logic [3:0] PAT_CH0_CH2 = 4'h5;
  localparam int ST_OT_LO = 12;
  localparam int ST_OC_LO = 8;
  localparam int ST_OL_LO = 4;
  localparam int ST_OV = 3;
  localparam int ST_WATCHDOG_EXPIRED_FLAG = 2;
  localparam int ST_UV = 1;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_PERIOD_NS = 3200;
  localparam int OSC_DIV_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OSC_W = 6;
  localparam int WD_CNT_W = 16;
  typedef enum logic [1:0] {QSW_SLEEP, QSW_NORMAL, QSW_FAULT, QSW_FAILSAFE} qsw_mode_e;
endpackage : qsw_pkg

// ==== qsw_sup_assertions.sv ====
// Concurrent checks on the quad switch supervisor ports
`timescale 1ns/1ps
module qsw_sup_assertions
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_CS_N,
  input wire logic O_SDO_OE_N,
  input wire logic I_WAKE,
  input wire logic I_INIT_N,
  input wire logic [1:0] I_FAILSAFE_SELECT,
  input wire logic [qsw_pkg::CH_N-1:0] I_OVERTEMP,
  input wire logic [qsw_pkg::CH_N-1:0] I_OVERCURRENT_LOW,
  input wire logic [qsw_pkg::CH_N-1:0] I_OVERCURRENT_HIGH,
  input wire logic [qsw_pkg::CH_N-1:0] I_OPEN_LOAD,
  input wire logic I_OVERVOLTAGE,
  input wire logic I_UNDERVOLTAGE,
  input wire logic [qsw_pkg::CH_N-1:0] O_OUTPUT_CHANNEL,
  input wire logic O_FAULT_FLAG_N_O,
  input wire logic O_FAULT_FLAG_N_OE_N,
  input wire qsw_pkg::qsw_mode_e O_MODE,
  input wire logic O_WATCHDOG_EXPIRED_FLAG,
  input wire logic [2:0] O_OVERCURRENT_LOW_LEVEL,
  input wire logic O_OVERCURRENT_HIGH_LEVEL,
  input wire logic [2:0] O_OVERCURRENT_TIME_SETTING,
  input wire logic [qsw_pkg::CH_N-1:0] O_OVERTEMP_LATCH_MODE
);
  import qsw_pkg::*;
  logic [3:0] pat;
  wire fault_any = |{I_OVERTEMP, I_OVERCURRENT_LOW, I_OVERCURRENT_HIGH, I_OPEN_LOAD,
                     I_OVERVOLTAGE, I_UNDERVOLTAGE};
  always_comb
  begin
    pat = PAT_ALL_OFF;
    if (I_FAILSAFE_SELECT == FS_CH0) pat = PAT_CH0;
    if (I_FAILSAFE_SELECT == FS_CH0_CH2) pat = PAT_CH0_CH2;
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  property p_sleep_entry;
    (!I_WAKE && !I_INIT_N) [*5] |-> O_MODE == QSW_SLEEP;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("not asleep");
  property p_sleep_outputs;
    O_MODE == QSW_SLEEP [*3] |-> O_OUTPUT_CHANNEL == 4'h0;
  endproperty
  a_sleep_outputs: assert property (p_sleep_outputs) else $error("output on in sleep");
  property p_sleep_settings;
    O_MODE == QSW_SLEEP [*3] |-> {O_OVERCURRENT_LOW_LEVEL, O_OVERCURRENT_HIGH_LEVEL,
      O_OVERCURRENT_TIME_SETTING, O_OVERTEMP_LATCH_MODE} == 11'h0;
  endproperty
  a_sleep_settings: assert property (p_sleep_settings) else $error("setting in sleep");
  property p_fs_flag;
    $rose(O_WATCHDOG_EXPIRED_FLAG) |-> ##[0:1] O_MODE == QSW_FAILSAFE;
  endproperty
  a_fs_flag: assert property (p_fs_flag) else $error("flag without fail-safe");
  property p_fs_pattern;
    (O_MODE == QSW_FAILSAFE) [*3] ##0 ($past(I_FAILSAFE_SELECT, 5) == I_FAILSAFE_SELECT)
      |-> (O_OUTPUT_CHANNEL & ~pat) == 4'h0;
  endproperty
  a_fs_pattern: assert property (p_fs_pattern) else $error("fail-safe pattern");
  property p_fs_defaults;
    $rose(O_WATCHDOG_EXPIRED_FLAG) |-> ##[0:2] (O_OVERCURRENT_LOW_LEVEL == DEF_OCL &&
      O_OVERCURRENT_HIGH_LEVEL == DEF_OCH && O_OVERCURRENT_TIME_SETTING == DEF_OCT &&
      O_OVERTEMP_LATCH_MODE == DEF_OTL);
  endproperty
  a_fs_defaults: assert property (p_fs_defaults) else $error("settings not default");
  property p_fs_grounded;
    (I_FAILSAFE_SELECT == FS_DISABLED) [*5] |-> !O_WATCHDOG_EXPIRED_FLAG;
  endproperty
  a_fs_grounded: assert property (p_fs_grounded) else $error("fail-safe while grounded");
  property p_fault_pin;
    fault_any [*4] |-> !O_FAULT_FLAG_N_OE_N && !O_FAULT_FLAG_N_O;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin released");
  property p_sdo_float;
    I_CS_N |-> O_SDO_OE_N;
  endproperty
  a_sdo_float: assert property (p_sdo_float) else $error("serial out driven");
  c_failsafe: cover property ($rose(O_WATCHDOG_EXPIRED_FLAG));
  c_normal: cover property (O_MODE == QSW_NORMAL);
  c_frame: cover property (!O_SDO_OE_N);
endmodule : qsw_sup_assertions

// ==== qsw_supervisor.sv ====
// Mode, watchdog, fail-safe, fault pin and serial link logic of the quad switch
`timescale 1ns/1ps
module qsw_supervisor
#(
  parameter int unsigned WD_TICKS_0 = 256,
  parameter int unsigned WD_TICKS_1 = 512,
  parameter int unsigned WD_TICKS_2 = 1024,
  parameter int unsigned WD_TICKS_3 = 2048
)
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_SDI,
  output logic O_SDO,
  output logic O_SDO_OE_N,
  input wire logic I_WAKE,
  input wire logic I_INIT_N,
  input wire logic I_LOGIC_SUPPLY_OK,
  input wire logic I_BATTERY_SUPPLY_OK,
  input wire logic [1:0] I_FAILSAFE_SELECT,
  input wire logic [qsw_pkg::CH_N-1:0] I_DIRECT_INPUT,
  input wire logic [qsw_pkg::CH_N-1:0] I_OVERTEMP,
  input wire logic [qsw_pkg::CH_N-1:0] I_OVERCURRENT_LOW,
  input wire logic [qsw_pkg::CH_N-1:0] I_OVERCURRENT_HIGH,
  input wire logic [qsw_pkg::CH_N-1:0] I_OPEN_LOAD,
  input wire logic I_OVERVOLTAGE,
  input wire logic I_UNDERVOLTAGE,
  output logic [qsw_pkg::CH_N-1:0] O_OUTPUT_CHANNEL,
  output logic O_FAULT_FLAG_N_O,
  output logic O_FAULT_FLAG_N_OE_N,
  output qsw_pkg::qsw_mode_e O_MODE,
  output logic O_WATCHDOG_EXPIRED_FLAG,
  output logic [2:0] O_OVERCURRENT_LOW_LEVEL,
  output logic O_OVERCURRENT_HIGH_LEVEL,
  output logic [2:0] O_OVERCURRENT_TIME_SETTING,
  output logic [qsw_pkg::CH_N-1:0] O_OVERTEMP_LATCH_MODE
);
  import qsw_pkg::*;

  localparam int AW = 7 + 5 * CH_N + 2;

  function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [1:0] sel);
    case (sel)
      2'h0: wd_limit = WD_CNT_W'(WD_TICKS_0);
      2'h1: wd_limit = WD_CNT_W'(WD_TICKS_1);
      2'h2: wd_limit = WD_CNT_W'(WD_TICKS_2);
      default: wd_limit = WD_CNT_W'(WD_TICKS_3);
    endcase
  endfunction : wd_limit

  function automatic logic [CH_N-1:0] fs_pattern(input logic [1:0] sel);
    case (sel)
      FS_ALL_OFF: fs_pattern = PAT_ALL_OFF;
      FS_CH0: fs_pattern = PAT_CH0;
      FS_CH0_CH2: fs_pattern = PAT_CH0_CH2;
      default: fs_pattern = PAT_ALL_OFF;
    endcase
  endfunction : fs_pattern

  // Pin synchronisers
  logic [AW-1:0] async_in;
  logic [AW-1:0] sync1_q;
  logic [AW-1:0] sync2_q;
  logic cs_n_s;
  logic wake_s;
  logic init_s;
  logic vdd_ok_s;
  logic battery_supply_ok_s;
  logic [1:0] fs_sel_s;
  logic [CH_N-1:0] din_s;
  logic [CH_N-1:0] ot_s;
  logic [CH_N-1:0] ocl_s;
  logic [CH_N-1:0] och_s;
  logic [CH_N-1:0] ol_s;
  logic ov_s;
  logic uv_s;

  assign async_in = {I_CS_N, I_WAKE, I_INIT_N, I_LOGIC_SUPPLY_OK, I_BATTERY_SUPPLY_OK,
                     I_FAILSAFE_SELECT, I_DIRECT_INPUT, I_OVERTEMP, I_OVERCURRENT_LOW,
                     I_OVERCURRENT_HIGH, I_OPEN_LOAD, I_OVERVOLTAGE, I_UNDERVOLTAGE};

  always_ff @(posedge I_MCLK)
  begin
    sync1_q <= async_in;
    sync2_q <= sync1_q;
  end

  assign {cs_n_s, wake_s, init_s, vdd_ok_s, battery_supply_ok_s, fs_sel_s, din_s, ot_s, ocl_s,
          och_s, ol_s, ov_s, uv_s} = sync2_q;

  // Serial link, clocked by the host; frame state is cleared by chip select
  logic [WORD_W-1:0] rx_sh_q;
  logic [CNT_W-1:0] rx_cnt_q;
  logic rx_started_q;
  logic [CNT_W-1:0] tx_cnt_q;
  logic [WORD_W-1:0] tx_word_q;

  always_ff @(negedge I_SCLK or posedge I_CS_N)
  begin
    if (I_CS_N)
      rx_started_q <= 1'b0; // [R24]
    else
      rx_started_q <= 1'b1;
  end

  always_ff @(negedge I_SCLK)
  begin
    if (!I_CS_N)
    begin
      rx_sh_q <= {rx_sh_q[WORD_W-2:0], I_SDI}; // [R01] [R23]
      if (!rx_started_q)
        rx_cnt_q <= 5'h01;
      else if (rx_cnt_q != 5'h1f)
        rx_cnt_q <= rx_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge I_SCLK or posedge I_CS_N)
  begin
    if (I_CS_N)
    begin
      tx_cnt_q <= 5'h00;
      O_SDO <= 1'b0;
      O_SDO_OE_N <= 1'b1; // [R24]
    end
    else
    begin
      O_SDO_OE_N <= 1'b0;
      if (tx_cnt_q < WORD_BITS)
      begin
        O_SDO <= tx_word_q[4'(5'(WORD_W - 1) - tx_cnt_q)]; // [R01] [R23]
        tx_cnt_q <= tx_cnt_q + 5'h01;
      end
      else
        O_SDO <= 1'b0;
    end
  end

  // Edge detection on the system clock
  logic cs_prev_q;
  logic wake_prev_q;
  logic init_prev_q;
  logic [CH_N-1:0] on_prev_q;
  logic [CH_N-1:0] cmd_on;
  logic cs_rise;
  logic cs_fall;
  logic arm_edge;
  logic [CH_N-1:0] on_rise;

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      cs_prev_q <= 1'b1;
      wake_prev_q <= 1'b0;
      init_prev_q <= 1'b0;
      on_prev_q <= '0;
    end
    else
    begin
      cs_prev_q <= cs_n_s;
      wake_prev_q <= wake_s;
      init_prev_q <= init_s;
      on_prev_q <= cmd_on;
    end
  end

  assign cs_rise = cs_n_s & ~cs_prev_q;
  assign cs_fall = ~cs_n_s & cs_prev_q;
  assign arm_edge = (wake_s & ~wake_prev_q) | (init_s & ~init_prev_q);
  assign on_rise = cmd_on & ~on_prev_q;

  // Frame acceptance
  logic frame_bad_q;
  logic valid;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST || cs_fall)
      frame_bad_q <= 1'b0;
    else if (!cs_n_s && !init_s)
      frame_bad_q <= 1'b1; // [R02]
  end

  assign valid = cs_rise & (rx_cnt_q == WORD_BITS) & ~frame_bad_q & init_s; // [R02] [R22]
  assign addr = rx_sh_q[ADDR_LO +: ADDR_W];
  assign data = rx_sh_q[DATA_W-1:0];

  // Mode conditions
  qsw_mode_e mode_q;
  logic sleep_req;
  logic fs_en;
  logic failsafe_q;
  logic expire;
  logic enter_fs;
  logic fault_any;

  assign sleep_req = ~wake_s & ~init_s; // [R05]
  assign fs_en = (fs_sel_s != FS_DISABLED); // [R16] [R25]
  assign enter_fs = expire & fs_en & ~failsafe_q;

  // Configuration registers
  logic [CH_N-1:0] spi_on_q;
  logic [CH_N-1:0] in_en_q;
  logic [2:0] ocl_lvl_q;
  logic och_lvl_q;
  logic [2:0] oct_q;
  logic [CH_N-1:0] otl_q;
  logic [1:0] wdr_q;

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST || !vdd_ok_s || !init_s)
    begin
      spi_on_q <= DEF_SPI_ON; // [R17]
      in_en_q <= DEF_IN_EN;
      ocl_lvl_q <= DEF_OCL;
      och_lvl_q <= DEF_OCH;
      oct_q <= DEF_OCT;
      otl_q <= DEF_OTL;
      wdr_q <= DEF_WDR;
    end
    else if (enter_fs)
    begin
      ocl_lvl_q <= DEF_OCL; // [R13]
      och_lvl_q <= DEF_OCH;
      oct_q <= DEF_OCT;
      otl_q <= DEF_OTL;
    end
    else if (valid)
    begin
      case (addr) // [R22]
        ADDR_OUTPUT:
        begin
          spi_on_q <= data[OUT_ON_LO +: CH_N];
          in_en_q <= data[OUT_EN_LO +: CH_N];
        end
        ADDR_OVERCURRENT:
        begin
          ocl_lvl_q <= data[OCL_LO +: 3];
          och_lvl_q <= data[OCH_BIT];
          oct_q <= data[OCT_LO +: 3];
        end
        ADDR_OVERTEMP: otl_q <= data[OTL_LO +: CH_N];
        ADDR_WATCHDOG: wdr_q <= data[WDR_LO +: 2];
        default: ;
      endcase
    end
  end

  // Settings as seen by the rest of the device; Sleep forces them to zero
  logic in_sleep;
  logic [CH_N-1:0] spi_on_eff;
  logic [CH_N-1:0] in_en_eff;
  logic [CH_N-1:0] otl_eff;

  assign in_sleep = (mode_q == QSW_SLEEP);
  assign spi_on_eff = in_sleep ? '0 : spi_on_q; // [R06]
  assign in_en_eff = in_sleep ? '0 : in_en_q; // [R06]
  assign otl_eff = in_sleep ? '0 : otl_q; // [R06]
  assign cmd_on = vdd_ok_s ? (spi_on_eff | (din_s & in_en_eff)) : din_s; // [R17]

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST || in_sleep)
    begin
      O_OVERCURRENT_LOW_LEVEL <= 3'h0; // [R06]
      O_OVERCURRENT_HIGH_LEVEL <= 1'b0;
      O_OVERCURRENT_TIME_SETTING <= 3'h0;
      O_OVERTEMP_LATCH_MODE <= '0;
    end
    else
    begin
      O_OVERCURRENT_LOW_LEVEL <= ocl_lvl_q;
      O_OVERCURRENT_HIGH_LEVEL <= och_lvl_q;
      O_OVERCURRENT_TIME_SETTING <= oct_q;
      O_OVERTEMP_LATCH_MODE <= otl_q;
    end
  end

  // Internal oscillator derived from the system clock
  logic [OSC_W-1:0] osc_cnt_q;
  logic osc_tick;

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST || osc_tick)
      osc_cnt_q <= '0;
    else
      osc_cnt_q <= osc_cnt_q + 1'b1;
  end

  assign osc_tick = (osc_cnt_q == OSC_W'(OSC_DIV_CYCLES - 1)); // [R09]

  // Watchdog
  logic wd_active_q;
  logic wd_last_q;
  logic [WD_CNT_W-1:0] wd_cnt_q;
  logic wd_toggle;

  assign wd_toggle = valid & (rx_sh_q[WD_BIT] != wd_last_q); // [R10]
  assign expire = wd_active_q & osc_tick & (wd_cnt_q == wd_limit(wdr_q) - 1'b1); // [R09]

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST || sleep_req || !fs_en || failsafe_q)
      wd_active_q <= 1'b0; // [R16]
    else if (arm_edge)
      wd_active_q <= 1'b1; // [R08]
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
      wd_last_q <= 1'b0;
    else if (valid)
      wd_last_q <= rx_sh_q[WD_BIT];
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST || !wd_active_q || wd_toggle || arm_edge)
      wd_cnt_q <= '0; // [R10]
    else if (osc_tick)
      wd_cnt_q <= wd_cnt_q + 1'b1;
  end

  // Fail-safe latch
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST || sleep_req || !fs_en)
      failsafe_q <= 1'b0; // [R15] [R16]
    else if (expire)
      failsafe_q <= 1'b1; // [R11]
  end

  // Latched faults; a new switch-on command clears them, a fresh event wins
  logic [CH_N-1:0] oc_latch_q;
  logic [CH_N-1:0] ot_latch_q;
  logic [CH_N-1:0] uv_latch_q;
  logic [CH_N-1:0] blocked;

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      oc_latch_q <= '0;
      ot_latch_q <= '0;
      uv_latch_q <= '0;
    end
    else
    begin
      oc_latch_q <= (oc_latch_q & ~on_rise) | ocl_s | och_s; // [R19] [R20]
      ot_latch_q <= (ot_latch_q & ~on_rise) | (ot_s & ~otl_eff); // [R19] [R20]
      uv_latch_q <= (uv_latch_q & ~on_rise) | ({CH_N{uv_s}} & cmd_on); // [R19] [R20]
    end
  end

  assign blocked = oc_latch_q | ot_latch_q | uv_latch_q | ot_s | ocl_s | och_s
                   | {CH_N{ov_s | uv_s}};
  assign fault_any = (|(blocked | ol_s)) | ov_s | uv_s; // [R18]

  // Fault pin is open drain: enable low pulls it down
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      O_FAULT_FLAG_N_O <= 1'b0;
      O_FAULT_FLAG_N_OE_N <= 1'b1;
    end
    else
    begin
      O_FAULT_FLAG_N_O <= 1'b0;
      O_FAULT_FLAG_N_OE_N <= ~fault_any; // [R07] [R18] [R19]
    end
  end

  // Operating mode
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
      mode_q <= QSW_SLEEP; // [R04]
    else if (sleep_req)
      mode_q <= QSW_SLEEP; // [R05]
    else
    begin
      case (mode_q) // [R03]
        QSW_SLEEP, QSW_NORMAL, QSW_FAULT:
        begin
          if (failsafe_q)
            mode_q <= QSW_FAILSAFE; // [R11]
          else if (fault_any || !vdd_ok_s || !battery_supply_ok_s || !init_s)
            mode_q <= QSW_FAULT;
          else
            mode_q <= QSW_NORMAL; // [R07]
        end
        QSW_FAILSAFE:
          if (!failsafe_q)
            mode_q <= fault_any ? QSW_FAULT : QSW_NORMAL; // [R15]
        default: mode_q <= QSW_SLEEP;
      endcase
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      O_MODE <= QSW_SLEEP;
      O_WATCHDOG_EXPIRED_FLAG <= 1'b0;
    end
    else
    begin
      O_MODE <= mode_q;
      O_WATCHDOG_EXPIRED_FLAG <= failsafe_q; // [R14]
    end
  end

  // Output channels
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
      O_OUTPUT_CHANNEL <= '0; // [R04]
    else
    begin
      case (mode_q)
        QSW_SLEEP: O_OUTPUT_CHANNEL <= '0; // [R05]
        QSW_FAILSAFE: O_OUTPUT_CHANNEL <= fs_pattern(fs_sel_s) & ~blocked; // [R12]
        QSW_NORMAL, QSW_FAULT: O_OUTPUT_CHANNEL <= cmd_on & ~blocked; // [R17]
        default: O_OUTPUT_CHANNEL <= '0;
      endcase
    end
  end

  // Fault register and the status word shifted out in the next frame
  logic [WORD_W-1:0] fault_ev;
  logic [WORD_W-1:0] fault_reg_q;

  always_comb
  begin
    fault_ev = '0;
    fault_ev[ST_OT_LO +: CH_N] = ot_s;
    fault_ev[ST_OC_LO +: CH_N] = ocl_s | och_s;
    fault_ev[ST_OL_LO +: CH_N] = ol_s;
    fault_ev[ST_OV] = ov_s;
    fault_ev[ST_UV] = uv_s;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST || !vdd_ok_s)
      fault_reg_q <= '0; // [R17]
    else if (valid)
      fault_reg_q <= (fault_reg_q & ~tx_word_q) | fault_ev; // [R21]
    else
      fault_reg_q <= fault_reg_q | fault_ev; // [R21]
  end

  // Held still while chip select is low, so the link side reads a stable word
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
      tx_word_q <= '0;
    else if (cs_n_s)
    begin
      tx_word_q <= fault_reg_q | fault_ev; // [R22]
      tx_word_q[ST_WATCHDOG_EXPIRED_FLAG] <= failsafe_q; // [R14]
    end
  end

endmodule : qsw_supervisor

// ==== quad_switch_mode_watchdog_failsafe_test.sv ====
// Self-checking bench for the quad switch supervisor
`timescale 1ns/1ps
module quad_switch_mode_watchdog_failsafe_test;
  import qsw_pkg::*;
  logic mclk, rst, sclk, cs_n, sdi, sdo, sdo_oe_n, wake, init_n, lsup, bsup, ov, uv;
  logic ff_o, ff_oe_n, wdf, ochl, tog;
  logic [1:0] sel;
  logic [3:0] din, ot, ocl, och, ol, outs, otl;
  logic [2:0] ocll, octs;
  logic [15:0] rx;
  qsw_mode_e mode;
  int err_total, n_checks, cyc, n;
  wire fault_pin = ff_oe_n ? 1'b1 : ff_o;
  qsw_supervisor #(.WD_TICKS_0(4), .WD_TICKS_1(8), .WD_TICKS_2(16), .WD_TICKS_3(32)) i_dut (
    .I_MCLK(mclk), .I_RST(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_SDI(sdi), .O_SDO(sdo),
    .O_SDO_OE_N(sdo_oe_n), .I_WAKE(wake), .I_INIT_N(init_n), .I_LOGIC_SUPPLY_OK(lsup),
    .I_BATTERY_SUPPLY_OK(bsup), .I_FAILSAFE_SELECT(sel), .I_DIRECT_INPUT(din),
    .I_OVERTEMP(ot), .I_OVERCURRENT_LOW(ocl), .I_OVERCURRENT_HIGH(och), .I_OPEN_LOAD(ol),
    .I_OVERVOLTAGE(ov), .I_UNDERVOLTAGE(uv), .O_OUTPUT_CHANNEL(outs),
    .O_FAULT_FLAG_N_O(ff_o), .O_FAULT_FLAG_N_OE_N(ff_oe_n), .O_MODE(mode),
    .O_WATCHDOG_EXPIRED_FLAG(wdf), .O_OVERCURRENT_LOW_LEVEL(ocll),
    .O_OVERCURRENT_HIGH_LEVEL(ochl), .O_OVERCURRENT_TIME_SETTING(octs),
    .O_OVERTEMP_LATCH_MODE(otl));
  qsw_host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo),
    .i_sdo_oe_n(sdo_oe_n));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total++;
      $display("MISMATCH t=%0t run too long", $time);
      give_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cw(input int k);
    repeat (k) @(negedge mclk);
  endtask : cw
  // One accepted frame; bit 15 flips each time to service the watchdog
  task automatic send(input logic [4:0] addr, input logic [9:0] data);
    tog = ~tog;
    i_host.xfer({tog, addr, data}, 16, rx);
    cw(4);
  endtask : send
  task automatic t_reset();
    chk(16'(mode), 16'(QSW_SLEEP), "mode");
    chk(16'(outs), 16'h0, "outputs");
    chk(16'(fault_pin), 16'h1, "fault pin");
  endtask : t_reset
  task automatic t_normal();
    init_n = 1'b1;
    cw(6);
    chk(16'(mode), 16'(QSW_NORMAL), "mode");
    chk(16'(fault_pin), 16'h1, "fault pin");
    cw(300);
    chk(16'(wdf), 16'h0, "expired");
  endtask : t_normal
  task automatic t_frames();
    send(ADDR_OUTPUT, 10'h00f);
    chk(16'(outs), 16'hf, "outputs");
    i_host.xfer({~tog, ADDR_OUTPUT, 10'h000}, 15, rx);
    cw(4);
    chk(16'(outs), 16'hf, "short frame");
  endtask : t_frames
  task automatic t_faults();
    ov = 1'b1;
    cw(5);
    chk(16'(fault_pin), 16'h0, "fault pin");
    ov = 1'b0;
    cw(5);
    chk(16'(fault_pin), 16'h1, "fault pin");
    send(5'h00, 10'h000);
    chk(16'(rx[ST_OV]), 16'h1, "status");
    send(5'h00, 10'h000);
    chk(16'(rx[ST_OV]), 16'h0, "status");
    och = 4'h2;
    cw(5);
    och = 4'h0;
    cw(5);
    chk(16'(fault_pin), 16'h0, "latched");
    send(ADDR_OUTPUT, 10'h00d);
    send(ADDR_OUTPUT, 10'h00f);
    chk(16'(fault_pin), 16'h1, "released");
  endtask : t_faults
  task automatic t_supply();
    lsup = 1'b0;
    din = 4'ha;
    cw(6);
    chk(16'(outs), 16'ha, "direct");
    chk(16'(ocll), 16'(DEF_OCL), "default");
    lsup = 1'b1;
    din = 4'h0;
    cw(6);
    bsup = 1'b0;
    cw(6);
    chk(16'(mode), 16'(QSW_FAULT), "battery");
    bsup = 1'b1;
    cw(6);
  endtask : t_supply
  task automatic t_watchdog();
    sel = FS_CH0_CH2;
    wake = 1'b1;
    cw(4);
    send(ADDR_WATCHDOG, 10'h001);
    cw(200);
    chk(16'(wdf), 16'h0, "long period");
    send(ADDR_OVERCURRENT, 10'h07f);
    chk(16'({ocll, ochl, octs}), 16'h7f, "settings");
    send(ADDR_OVERTEMP, 10'h00f);
    chk(16'(otl), 16'hf, "latch mode");
    send(ADDR_OUTPUT, 10'h00f);
    send(ADDR_WATCHDOG, 10'h000);
    n = 0;
    while (wdf !== 1'b1 && n < 400)
    begin
      cw(1);
      n++;
    end
    chk(16'(n > 60 && n < 160), 16'h1, "expiry time");
    din = 4'h2;
    cw(4);
    chk(16'(mode), 16'(QSW_FAILSAFE), "mode");
    chk(16'(outs), 16'(PAT_CH0_CH2), "pattern");
    chk(16'({ocll, ochl, octs, otl}), 16'({DEF_OCL, DEF_OCH, DEF_OCT, DEF_OTL}), "dflt");
    send(5'h00, 10'h000);
    chk(16'(rx[ST_WATCHDOG_EXPIRED_FLAG]), 16'h1, "status");
    chk(16'(mode), 16'(QSW_FAILSAFE), "held");
    sel = FS_CH0;
    cw(5);
    chk(16'(outs), 16'(PAT_CH0), "pattern");
    sel = FS_ALL_OFF;
    cw(5);
    chk(16'(outs), 16'(PAT_ALL_OFF), "pattern");
    sel = FS_DISABLED;
    cw(5);
    chk(16'({wdf, mode == QSW_FAILSAFE}), 16'h0, "exit");
    din = 4'h0;
  endtask : t_watchdog
  task automatic t_sleep();
    send(ADDR_OUTPUT, 10'h00f);
    wake = 1'b0;
    init_n = 1'b0;
    cw(6);
    chk(16'(mode), 16'(QSW_SLEEP), "mode");
    chk(16'(outs), 16'h0, "outputs");
    chk(16'({ocll, octs}), 16'h0, "settings");
  endtask : t_sleep
  initial
  begin
    {rst, wake, init_n, lsup, bsup, ov, uv, tog} = 8'h98;
    {sel, din, ot, ocl, och, ol} = 18'h0;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    cw(10);
    rst = 1'b0;
    cw(3);
    t_reset();
    t_normal();
    t_frames();
    t_faults();
    t_supply();
    t_watchdog();
    t_sleep();
    give_verdict();
  end
endmodule : quad_switch_mode_watchdog_failsafe_test
bind qsw_supervisor qsw_sup_assertions i_chk (.I_MCLK(I_MCLK), .I_RST(I_RST),
  .I_CS_N(I_CS_N), .O_SDO_OE_N(O_SDO_OE_N), .I_WAKE(I_WAKE), .I_INIT_N(I_INIT_N),
  .I_FAILSAFE_SELECT(I_FAILSAFE_SELECT), .I_OVERTEMP(I_OVERTEMP),
  .I_OVERCURRENT_LOW(I_OVERCURRENT_LOW), .I_OVERCURRENT_HIGH(I_OVERCURRENT_HIGH),
  .I_OPEN_LOAD(I_OPEN_LOAD), .I_OVERVOLTAGE(I_OVERVOLTAGE), .I_UNDERVOLTAGE(I_UNDERVOLTAGE),
  .O_OUTPUT_CHANNEL(O_OUTPUT_CHANNEL), .O_FAULT_FLAG_N_O(O_FAULT_FLAG_N_O),
  .O_FAULT_FLAG_N_OE_N(O_FAULT_FLAG_N_OE_N), .O_MODE(O_MODE),
  .O_WATCHDOG_EXPIRED_FLAG(O_WATCHDOG_EXPIRED_FLAG),
  .O_OVERCURRENT_LOW_LEVEL(O_OVERCURRENT_LOW_LEVEL),
  .O_OVERCURRENT_HIGH_LEVEL(O_OVERCURRENT_HIGH_LEVEL),
  .O_OVERCURRENT_TIME_SETTING(O_OVERCURRENT_TIME_SETTING),
  .O_OVERTEMP_LATCH_MODE(O_OVERTEMP_LATCH_MODE));
